// ---- rtl/aie_core.sv ----
// Accumulator instruction executor with an AXI4-Lite register slave
//
// Operation
// - OR literal into accumulator, update zero
// - Load literal into accumulator, flags untouched
// - OR accumulator with file, route, update zero
// - Target bit 0 to accumulator, 1 to file
// - Store accumulator to file, flags untouched
// - Move file to target, update zero
// - Move to itself rewrites value, updates zero
// - Return: stack top to counter, enable irqs
// - Rotate left through carry, only carry changes
// - Rotate result routed by target bit
// - Return pops the hardware stack
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module aie_core
    import aie_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   irq_master_on
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Offsets answered by this slave
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == REG_INSTR) || (a == REG_ACC) || (a == REG_STAT) ||
               (a == REG_PC) || (a == REG_FADDR) || (a == REG_FDATA) ||
               (a == REG_STACK);
    endfunction

    // Byte enables widened to a bit mask
    function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [ADDR_W-1:0]  awaddr_q;        // Held write address
    logic               aw_full_q;       // Address captured
    logic [DATA_W-1:0]  wdata_q;         // Held write data
    logic [3:0]         wstrb_q;         // Held byte enables
    logic               w_full_q;        // Data captured
    logic [INSTR_W-1:0] instr_q;         // Last instruction word
    logic               exec_q;          // One-cycle run pulse
    logic [7:0]         acc_q;           // Accumulator
    logic               z_q;             // Zero flag
    logic               c_q;             // Carry flag
    logic [PC_W-1:0]    pc_q;            // Program counter
    logic [FADDR_W-1:0] faddr_q;         // Software file pointer
    logic [PC_W-1:0]    stk_q [STK_N];   // Return stack
    logic [STK_W-1:0]   sp_q;            // Next free stack slot

    aie_file_if fp ();

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    logic              wr_go;       // Both halves held, no response owed
    logic [DATA_W-1:0] wr_mask;     // Bit mask from strobes
    logic              wr_hit;      // Address is mapped
    assign wr_go   = aw_full_q && w_full_q && !bvalid;
    assign wr_mask = lane_mask(wstrb_q);
    assign wr_hit  = is_mapped(awaddr_q);

    // Per-register write strobes
    logic wr_instr;
    logic wr_acc;
    logic wr_stat;
    logic wr_faddr;
    logic wr_fdata;
    logic wr_stack;
    assign wr_instr = wr_go && (awaddr_q == REG_INSTR);
    assign wr_acc   = wr_go && (awaddr_q == REG_ACC) && wstrb_q[0];
    assign wr_stat  = wr_go && (awaddr_q == REG_STAT) && wstrb_q[0];
    assign wr_faddr = wr_go && (awaddr_q == REG_FADDR) && wstrb_q[0];
    assign wr_fdata = wr_go && (awaddr_q == REG_FDATA) && wstrb_q[0];
    assign wr_stack = wr_go && (awaddr_q == REG_STACK) && wstrb_q[0];

    // ----------------------------------------
    // Instruction fields
    // ----------------------------------------
    aie_op_t            op;
    logic               tgt;
    logic [FADDR_W-1:0] f_addr;
    logic [7:0]         lit;
    logic [7:0]         f_rd;
    logic [PC_W-1:0]    stack_top;
    assign op        = aie_op_t'(instr_q[OP_LSB +: OP_W]);
    assign tgt       = instr_q[TGT_BIT];
    assign f_addr    = instr_q[FADDR_LSB +: FADDR_W];
    assign lit       = instr_q[LIT_LSB +: 8];
    assign f_rd      = fp.exec_data;
    assign stack_top = stk_q[sp_q - 3'h1];

    // ----------------------------------------
    // Execute datapath
    // ----------------------------------------
    logic [7:0] res;      // Result of the operation
    logic       to_acc;   // Result goes to the accumulator
    logic       to_file;  // Result goes to the file register
    logic       upd_z;    // Zero flag follows the result
    logic       upd_c;    // Carry takes old bit 7
    logic       do_ret;   // Pop and reload the counter

    // Unknown codes fall to the default and behave as idle
    always_comb
    begin
        res     = acc_q;
        to_acc  = 1'b0;
        to_file = 1'b0;
        upd_z   = 1'b0;
        upd_c   = 1'b0;
        do_ret  = 1'b0;
        case (op)
            OR_LITERAL_OP:
            begin
                res    = acc_q | lit;
                to_acc = 1'b1;
                upd_z  = 1'b1;
            end
            LOAD_LITERAL_OP:
            begin
                res    = lit;
                to_acc = 1'b1;
            end
            OR_FILE_OP:
            begin
                res     = acc_q | f_rd;
                to_acc  = !tgt;
                to_file = tgt;
                upd_z   = 1'b1;
            end
            STORE_ACCUMULATOR_OP:
            begin
                res     = acc_q;
                to_file = 1'b1;
            end
            MOVE_FILE_OP:
            begin
                // Rewriting the same value lets software test it for zero
                res     = f_rd;
                to_acc  = !tgt;
                to_file = tgt;
                upd_z   = 1'b1;
            end
            INTERRUPT_RETURN_OP:
            begin
                do_ret = 1'b1;
            end
            ROTATE_LEFT_OP:
            begin
                res     = {f_rd[6:0], c_q};
                to_acc  = !tgt;
                to_file = tgt;
                upd_c   = 1'b1;
            end
            default:
            begin
                res = acc_q;
            end
        endcase
    end

    // ----------------------------------------
    // File bank hookup
    // ----------------------------------------
    // Execute and software writes never share a cycle; execute wins anyway
    assign fp.exec_addr = f_addr;
    assign fp.bus_addr  = faddr_q;
    assign fp.we        = (exec_q && to_file) || wr_fdata;
    assign fp.waddr     = (exec_q && to_file) ? f_addr : faddr_q;
    assign fp.wdata     = (exec_q && to_file) ? res : wdata_q[7:0];

    aie_file_bank u_bank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .fp      (fp)
    );

    // ----------------------------------------
    // AXI write channels
    // ----------------------------------------
    // Address and data are taken in any order, held until the response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end
        else
        begin
            // Capture the address
            if (awvalid && awready)
            begin
                awaddr_q  <= awaddr;
                aw_full_q <= 1'b1;
                awready   <= 1'b0;
            end
            // Capture the data
            if (wvalid && wready)
            begin
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
                w_full_q <= 1'b1;
                wready   <= 1'b0;
            end
            // Commit and answer; unmapped offsets get SLVERR
            if (wr_go)
            begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            // Response taken, reopen both channels
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // AXI read channels
    // ----------------------------------------
    // One read at a time; data ready one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                REG_INSTR: rdata <= {12'h000, instr_q};
                REG_ACC:   rdata <= {24'h000000, acc_q};
                REG_STAT:  rdata <= {29'h00000000, irq_master_on, c_q, z_q};
                REG_PC:    rdata <= {19'h00000, pc_q};
                REG_FADDR: rdata <= {25'h0000000, faddr_q};
                REG_FDATA: rdata <= {24'h000000, fp.bus_data};
                REG_STACK: rdata <= {19'h00000, stack_top};
                default:   rdata <= 32'h00000000;
            endcase
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Instruction register and run pulse
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_q <= INSTR_RST;
            exec_q  <= 1'b0;
        end
        else
        begin
            exec_q <= wr_instr;
            if (wr_instr)
            begin
                instr_q <= (instr_q & ~wr_mask[INSTR_W-1:0]) |
                           (wdata_q[INSTR_W-1:0] & wr_mask[INSTR_W-1:0]);
            end
        end
    end

    // ----------------------------------------
    // Accumulator and pointer
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_q   <= ACC_RST;
            faddr_q <= 7'h00;
        end
        else
        begin
            if (exec_q && to_acc)
            begin
                acc_q <= res;
            end
            else if (wr_acc)
            begin
                acc_q <= wdata_q[7:0];
            end
            if (wr_faddr)
            begin
                faddr_q <= wdata_q[FADDR_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Only operations that own a flag touch it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            z_q           <= 1'b0;
            c_q           <= 1'b0;
            irq_master_on <= 1'b0;
        end
        else if (exec_q)
        begin
            if (upd_z)
            begin
                z_q <= (res == 8'h00);
            end
            if (upd_c)
            begin
                c_q <= f_rd[7];
            end
            if (do_ret)
            begin
                irq_master_on <= 1'b1;
            end
        end
        else if (wr_stat)
        begin
            z_q           <= wdata_q[STAT_Z];
            c_q           <= wdata_q[STAT_C];
            irq_master_on <= wdata_q[STAT_IRQ];
        end
    end

    // ----------------------------------------
    // Program counter and return stack
    // ----------------------------------------
    // The stack is circular: popping an empty stack wraps, as in hardware
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pc_q <= PC_RST;
            sp_q <= 3'h0;
            for (int i = 0; i < STK_N; i++)
            begin
                stk_q[i] <= PC_RST;
            end
        end
        else if (exec_q)
        begin
            if (do_ret)
            begin
                pc_q <= stack_top;
                sp_q <= sp_q - 3'h1;
            end
            else
            begin
                pc_q <= pc_q + 13'h0001;
            end
        end
        else if (wr_stack)
        begin
            stk_q[sp_q] <= (wdata_q[PC_W-1:0] & wr_mask[PC_W-1:0]);
            sp_q        <= sp_q + 3'h1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_or_lit_result: assert property (exec_q && op == OR_LITERAL_OP |=>
        acc_q == ($past(acc_q) | $past(lit)) && z_q == (acc_q == 8'h00))
        else $error("or literal result wrong");
    a_load_keep_flags: assert property (exec_q && op == LOAD_LITERAL_OP |=>
        acc_q == $past(lit) && $stable(z_q) && $stable(c_q))
        else $error("load literal wrong");
    a_or_file_zero: assert property (exec_q && op == OR_FILE_OP |=>
        z_q == (($past(acc_q) | $past(f_rd)) == 8'h00))
        else $error("or file zero wrong");
    a_target_route: assert property (exec_q && op == OR_FILE_OP && tgt |=>
        $stable(acc_q) && f_rd == ($past(acc_q) | $past(f_rd)))
        else $error("or file routing wrong");
    a_store_file: assert property (exec_q && op == STORE_ACCUMULATOR_OP |=>
        f_rd == $past(acc_q) && $stable(z_q) && $stable(c_q))
        else $error("store wrong");
    a_move_zero: assert property (exec_q && op == MOVE_FILE_OP && tgt |=>
        z_q == ($past(f_rd) == 8'h00) && $stable(f_rd) && $stable(acc_q))
        else $error("move to itself wrong");
    a_move_acc: assert property (exec_q && op == MOVE_FILE_OP && !tgt |=>
        acc_q == $past(f_rd) && z_q == (acc_q == 8'h00))
        else $error("move to accumulator wrong");
    a_return_pops: assert property (exec_q && op == INTERRUPT_RETURN_OP |=>
        pc_q == $past(stack_top) && irq_master_on && $stable(z_q) && $stable(c_q)
        && sp_q == $past(sp_q) - 3'h1)
        else $error("return wrong");
    a_rotate_carry: assert property (exec_q && op == ROTATE_LEFT_OP |=>
        c_q == $past(f_rd[7]) && $stable(z_q))
        else $error("rotate carry wrong");
    a_rotate_route: assert property (exec_q && op == ROTATE_LEFT_OP && !tgt |=>
        acc_q == {$past(f_rd[6:0]), $past(c_q)})
        else $error("rotate result wrong");
    a_idle_still: assert property (exec_q && op == IDLE_OP |=>
        $stable(acc_q) && $stable(z_q) && pc_q == $past(pc_q) + 13'h0001)
        else $error("idle changed state");

    c_rotate_file: cover property (exec_q && op == ROTATE_LEFT_OP && tgt);
    c_return: cover property (exec_q && op == INTERRUPT_RETURN_OP);
    c_move_zero: cover property (exec_q && op == MOVE_FILE_OP && f_rd == 8'h00);
endmodule

// ---- common/aie_pkg.sv ----
// Constants and types shared by the accumulator execution block
package aie_pkg;
    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] REG_INSTR = 8'h00;   // Write runs one instruction
    localparam logic [7:0] REG_ACC   = 8'h04;   // Accumulator
    localparam logic [7:0] REG_STAT  = 8'h08;   // Zero, carry, irq enable
    localparam logic [7:0] REG_PC    = 8'h0C;   // Program counter, read only
    localparam logic [7:0] REG_FADDR = 8'h10;   // File register pointer
    localparam logic [7:0] REG_FDATA = 8'h14;   // File register at pointer
    localparam logic [7:0] REG_STACK = 8'h18;   // Write pushes, read top

    // ----------------------------------------
    // Instruction word fields
    // ----------------------------------------
    localparam int OP_LSB    = 0;
    localparam int OP_W      = 4;
    localparam int TGT_BIT   = 4;
    localparam int FADDR_LSB = 5;
    localparam int LIT_LSB   = 12;
    localparam int INSTR_W   = 20;

    // ----------------------------------------
    // Status fields and sizes
    // ----------------------------------------
    localparam int STAT_Z   = 0;
    localparam int STAT_C   = 1;
    localparam int STAT_IRQ = 2;
    localparam int FADDR_W  = 7;
    localparam int FILE_N   = 128;
    localparam int PC_W     = 13;
    localparam int STK_N    = 8;
    localparam int STK_W    = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [7:0]  FILE_RST  = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [INSTR_W-1:0] INSTR_RST = 20'h00000;

    // Operation codes, numbered in declaration order
    typedef enum logic [OP_W-1:0] {
        IDLE_OP,
        OR_LITERAL_OP,
        LOAD_LITERAL_OP,
        OR_FILE_OP,
        STORE_ACCUMULATOR_OP,
        MOVE_FILE_OP,
        INTERRUPT_RETURN_OP,
        ROTATE_LEFT_OP
    } aie_op_t;
endpackage

// ---- common/aie_file_if.sv ----
// Ports between the execution core and its file register bank
`timescale 1ns/1ns
interface aie_file_if;
    logic [6:0] exec_addr;   // Operand address from the instruction
    logic [7:0] exec_data;   // Operand value
    logic [6:0] bus_addr;    // Software pointer
    logic [7:0] bus_data;    // Value at the pointer
    logic       we;          // Write strobe
    logic [6:0] waddr;       // Write address
    logic [7:0] wdata;       // Write value

    modport bank (input exec_addr, bus_addr, we, waddr, wdata,
                  output exec_data, bus_data);
    modport core (output exec_addr, bus_addr, we, waddr, wdata,
                  input exec_data, bus_data);
endinterface

// ---- rtl/aie_file_bank.sv ----
// File register bank: flip-flop storage with two read ports
`timescale 1ns/1ns
module aie_file_bank
    import aie_pkg::*;
(
    input  wire logic  aclk,
    input  wire logic  aresetn,
    aie_file_if.bank   fp
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] mem_q [FILE_N];   // One byte per address

    // Single write port, cleared at reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < FILE_N; i++)
            begin
                mem_q[i] <= FILE_RST;
            end
        end
        else if (fp.we)
        begin
            mem_q[fp.waddr] <= fp.wdata;
        end
    end

    // Reads are combinational so an instruction runs in one cycle
    assign fp.exec_data = mem_q[fp.exec_addr];
    assign fp.bus_data  = mem_q[fp.bus_addr];
endmodule

// ---- sim/test_aie_core.sv ----
// Self-checking bench for the accumulator execution core
`timescale 1ns/1ns
module test_aie_core
    import aie_pkg::*;
;
    // ------------
    // Signals and reference state
    // ------------
    logic              aclk      = 1'b0;
    logic              aresetn   = 1'b0;
    logic [ADDR_W-1:0] awaddr    = 8'h00;
    logic              awvalid   = 1'b0;
    logic              awready;
    logic [DATA_W-1:0] wdata     = 32'h0;
    logic [3:0]        wstrb     = 4'hF;
    logic              wvalid    = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic [ADDR_W-1:0] araddr    = 8'h00;
    logic              arvalid   = 1'b0;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              irq_on;
    int                err_total = 0;
    int                cmp_count = 0;
    logic [7:0]        m_acc, m_f [FILE_N];      // Reference accumulator, file bank
    logic [PC_W-1:0]   m_pc, m_stk [STK_N];      // Reference counter, stack
    logic [STK_W-1:0]  m_sp;
    logic [6:0]        fa;                       // Pointer last written
    logic              m_z, m_c, m_irq;

    // Ready on both answer channels is held high: legal, and keeps the tasks short
    aie_core i_aie_core (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .irq_master_on(irq_on));

    initial forever #5 aclk = ~aclk;

    // ------------
    // Compare, bus and model helpers
    // ------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Offsets past the stack register are unmapped
    function automatic logic [31:0] exp_resp(input logic [7:0] a);
        return (a > REG_STACK) ? {30'h0, RESP_SLVERR} : {30'h0, RESP_OKAY};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        chk("bresp", exp_resp(a), {30'h0, bresp});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr  <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        chk("rresp", exp_resp(a), {30'h0, rresp});
    endtask

    function automatic void model(input logic [19:0] iw);
        logic [7:0] fv;
        logic [7:0] res;
        logic [3:0] op;
        op   = iw[3:0];
        fv   = m_f[iw[11:5]];
        res  = m_acc | iw[19:12];
        m_pc = m_pc + 13'h0001;
        case (op)
            4'h2: res = iw[19:12];
            4'h3: res = m_acc | fv;
            4'h4: res = m_acc;
            4'h5: res = fv;
            4'h7: res = {fv[6:0], m_c};
            default: ;
        endcase
        if (op inside {4'h1, 4'h3, 4'h5})
            m_z = (res == 8'h00);
        if (op == 4'h7)
            m_c = fv[7];
        if (op inside {4'h1, 4'h2} || (op inside {4'h3, 4'h5, 4'h7} && !iw[4]))
            m_acc = res;
        if (op == 4'h4 || (op inside {4'h3, 4'h5, 4'h7} && iw[4]))
            m_f[iw[11:5]] = res;
        if (op == 4'h6)
        begin
            m_sp  = m_sp - 3'h1;
            m_pc  = m_stk[m_sp];
            m_irq = 1'b1;
        end
    endfunction

    // Bus write that also moves the reference state
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        case (a)
            REG_ACC:   m_acc = d[7:0];
            REG_STAT:  {m_irq, m_c, m_z} = d[2:0];
            REG_FADDR: fa = d[6:0];
            REG_FDATA: m_f[fa] = d[7:0];
            REG_STACK: m_stk[m_sp] = d[12:0];
            REG_INSTR: model(d[19:0]);
            default: ;
        endcase
        if (a == REG_STACK)
            m_sp = m_sp + 3'h1;
    endtask

    task automatic check_all();
        logic [31:0] v;
        rd(REG_ACC, v);
        chk("acc", {24'h0, m_acc}, v);
        rd(REG_STAT, v);
        chk("stat", {29'h0, m_irq, m_c, m_z}, v);
        rd(REG_PC, v);
        chk("pc", {19'h0, m_pc}, v);
        rd(REG_FDATA, v);
        chk("file", {24'h0, m_f[fa]}, v);
        rd(REG_STACK, v);
        chk("stack", {19'h0, m_stk[m_sp - 3'h1]}, v);
        chk("irq", {31'h0, m_irq}, {31'h0, irq_on});
    endtask

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------
    // Main sequence and watchdog
    // ------------
    initial
    begin
        logic [31:0] v;
        logic [19:0] iw;
        v = $urandom(32'h80384414);
        {m_acc, m_pc, m_sp, fa, m_z, m_c, m_irq} = '0;
        foreach (m_f[j]) m_f[j] = 8'h00;
        foreach (m_stk[j]) m_stk[j] = 13'h0000;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_all();
        rd(8'h40, v);
        chk("unmapped", 32'h0, v);
        put(8'h40, 32'hFF);
        put(REG_PC, 32'h1234);
        // Accumulator write without byte lane 0 must be dropped
        wstrb <= 4'hE;
        wr(REG_ACC, 32'h5A);
        wstrb <= 4'hF;
        check_all();
        // First 16 passes walk every code, both targets, zero operands
        for (int i = 0; i < 300; i++)
        begin
            iw = {8'($urandom), 7'($urandom), 1'($urandom), 4'($urandom)};
            if (i < 16)
                iw = {8'h00, 7'(i * 9), i[3], 1'b0, i[2:0]};
            put(REG_FADDR, {25'h0, iw[11:5]});
            put(REG_FDATA, i[0] ? 32'h0 : $urandom);
            put(REG_ACC, i[0] ? 32'h0 : $urandom);
            put(REG_STAT, (i < 16) ? {31'h1, ~i[0]} : $urandom);
            if (iw[3:0] == 4'h6)
                put(REG_STACK, $urandom);
            put(REG_INSTR, {12'h0, iw});
            check_all();
        end
        test_done();
    end

    initial
    begin
        repeat (40000) @(posedge aclk);
        err_total++;
        test_done();
    end
endmodule
